// >>> include/lar_pkg.sv
// Constants, register map and state codes of the reclose sequencer.
// What this block does
// - Removed function: pin inputs ignored, command outputs held low; the register bus still answers.
// - Active only while parameter, pin and interface sources are all on.
// - Start-up sets pin and interface sources on, even if interface was off.
// - Each source holds its own off state; only that source clears it.
// - At most eight reclose attempts per fault sequence, by cycle counter.
// - Cycles one to four have own settings; later cycles reuse the fourth.
// - With first-trip check on, breaker must be ready at first trip.
// - Per-cycle check: breaker ready checked at breaker-wait expiry; at dead-time end only with the extension bit.
// - Breaker-ready wait timer runs in dead time; expiry blocks if breaker is not ready.
// - Dead-time extension is capped by its limit; infinite means no cap.
// - Reclaim expiry resets the function; a re-trip starts the next cycle.
// - Fault in manual-close block time: no reclose, final three-pole trip.
// - Detection by pickup: the first pickup in dead time is an evolving fault.
// - Detection by trip: only a trip in dead time is an evolving fault.
// - Action block: no reclosure after an evolving fault.
// - Action three-pole: start separate three-pole dead time on the trip.
// - Open watch starts at trip; breaker still closed at expiry blocks.
// - Breaker open judged from auxiliary contact or trip going away.
// - Delayed remote close only when the far end uses adaptive dead time.
// - Trip type selects one- or three-pole dead time, or blocks reclosure.
package lar_pkg;
  localparam int unsigned CLK_HZ         = 40_000_000;
  localparam int unsigned TICK_US        = 1000;
  localparam int unsigned TICK_CYC       = CLK_HZ / 1_000_000 * TICK_US;
  localparam int unsigned TW             = 16;
  localparam logic [TW-1:0] T_INF        = 16'hffff;
  localparam logic [3:0]  MAX_CYC        = 4'h8;
  localparam int unsigned NSET           = 4;
  // Register byte offsets.
  localparam logic [7:0] A_CTRL     = 8'h00;
  localparam logic [7:0] A_STAT     = 8'h04;
  localparam logic [7:0] A_BRKWAIT  = 8'h08;
  localparam logic [7:0] A_DEADEXT  = 8'h0c;
  localparam logic [7:0] A_RECLAIM  = 8'h10;
  localparam logic [7:0] A_MCBLK    = 8'h14;
  localparam logic [7:0] A_OPENWT   = 8'h18;
  localparam logic [7:0] A_REMDLY   = 8'h1c;
  localparam logic [7:0] A_DEAD3EV  = 8'h20;
  localparam logic [7:0] A_CYC0     = 8'h40;
  // Control register bits.
  localparam int unsigned C_PARAM_ON  = 0;
  localparam int unsigned C_SI_OFF    = 1;
  localparam int unsigned C_SI_ON     = 2;
  localparam int unsigned C_CHK1      = 3;
  localparam int unsigned C_EV_TRIP   = 4;
  localparam int unsigned C_EV_3P     = 5;
  localparam int unsigned C_REM_ADAPT = 6;
  localparam int unsigned C_NCYC_LSB  = 8;
  localparam int unsigned C_NCYC_W    = 4;
  localparam logic [31:0] CTRL_RST    = 32'h0000_0101;
  // Per-cycle register: [15:0] 1p dead, [31:16] 3p dead, 0 = not allowed.
  localparam logic [31:0] CYC_RST     = 32'h0064_0032;
  localparam logic [31:0] T_RST       = 32'h0000_0064;
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_OPENW = 3'b001,
    ST_DEAD  = 3'b010,
    ST_EXT   = 3'b011,
    ST_CLOSE = 3'b100,
    ST_RECL  = 3'b101,
    ST_LOCK  = 3'b110
  } lar_state_e;
endpackage : lar_pkg

// >>> include/lar_tmr_if.sv
// Interface that carries the common tick and one timer's controls.
`timescale 1ns/1ps
`default_nettype none
interface lar_tmr_if;
  logic                  tick;
  logic                  start;
  logic                  stop;
  logic [lar_pkg::TW-1:0] load;
  logic                  expired;
  logic                  running;
  modport ctl (output tick, output start, output stop, output load,
               input expired, input running);
  modport tmr (input tick, input start, input stop, input load,
               output expired, output running);
endinterface : lar_tmr_if
`default_nettype wire

// >>> design/lar_timer.sv
// Tick-driven down counter used for every supervision timer.
`timescale 1ns/1ps
`default_nettype none
module lar_timer (
  // Clock and reset
  input  wire logic  clk_i,
  input  wire logic  rst_b_i,
  // Timer controls
  lar_tmr_if.tmr     t
);
  logic [lar_pkg::TW-1:0] cnt_ff, nxt_cnt;
  logic                   run_ff, nxt_run;
  logic                   exp_ff, nxt_exp;

  always_comb begin
    nxt_cnt = cnt_ff;
    nxt_run = run_ff;
    nxt_exp = 1'b0;
    if (t.stop) begin
      nxt_run = 1'b0;
    end else if (t.start) begin
      nxt_cnt = t.load;
      nxt_run = (t.load != '0);
      nxt_exp = (t.load == '0);
    end else if (run_ff && t.tick) begin
      if (cnt_ff <= lar_pkg::TW'(1)) begin
        nxt_cnt = '0;
        nxt_run = 1'b0;
        nxt_exp = 1'b1;
      end else begin
        nxt_cnt = cnt_ff - lar_pkg::TW'(1);
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cnt_ff <= '0;
      run_ff <= 1'b0;
      exp_ff <= 1'b0;
    end else begin
      cnt_ff <= nxt_cnt;
      run_ff <= nxt_run;
      exp_ff <= nxt_exp;
    end
  end

  assign t.expired = exp_ff;
  assign t.running = run_ff;
endmodule : lar_timer
`default_nettype wire

// >>> design/lar_top.sv
// Auto-reclose sequencer top with AXI4-Lite registers and supervision timers.
`timescale 1ns/1ps
`default_nettype none
module lar_top #(
  parameter bit PRESENT = 1'b1
) (
  // Clock and reset
  input  wire logic        CLOCK_I,
  input  wire logic        RST_B_I,
  // AXI4-Lite slave
  input  wire logic [7:0]  AWADDR_I,
  input  wire logic        AWVALID_I,
  output logic             AWREADY_O,
  input  wire logic [31:0] WDATA_I,
  input  wire logic [3:0]  WSTRB_I,
  input  wire logic        WVALID_I,
  output logic             WREADY_O,
  output logic [1:0]       BRESP_O,
  output logic             BVALID_O,
  input  wire logic        BREADY_I,
  input  wire logic [7:0]  ARADDR_I,
  input  wire logic        ARVALID_I,
  output logic             ARREADY_O,
  output logic [31:0]      RDATA_O,
  output logic [1:0]       RRESP_O,
  output logic             RVALID_O,
  input  wire logic        RREADY_I,
  // Protection and breaker pins
  input  wire logic        BI_ON_I,
  input  wire logic        BI_OFF_I,
  input  wire logic        PICKUP_I,
  input  wire logic        TRIP_1P_I,
  input  wire logic        TRIP_3P_I,
  input  wire logic        BRK_READY_I,
  input  wire logic        BRK_OPEN_I,
  input  wire logic        MAN_CLOSE_I,
  // Commands
  output logic             CLOSE_CMD_O,
  output logic             REMOTE_CLOSE_O,
  output logic             FINAL_TRIP_3P_O,
  output logic             RECL_ACTIVE_O
);
  localparam int unsigned NT = 7;
  localparam int unsigned NI = 8;
  localparam int unsigned TK_W = $clog2(lar_pkg::TICK_CYC);

  // Pin synchronisers: stage one feeds only stage two.
  logic [NI-1:0] s1_ff, s2_ff, prev_ff;
  always_ff @(posedge CLOCK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      s1_ff   <= '0;
      s2_ff   <= '0;
      prev_ff <= '0;
    end else begin
      s1_ff   <= {BI_ON_I, BI_OFF_I, PICKUP_I, TRIP_1P_I, TRIP_3P_I,
                  BRK_READY_I, BRK_OPEN_I, MAN_CLOSE_I};
      s2_ff   <= s1_ff;
      prev_ff <= s2_ff;
    end
  end
  logic bi_on, bi_off, pick, t1p, t3p, brdy, bopen, mclose, trip, trip_rise;
  logic mclose_rise;
  // Removed function ignores all its pin inputs.
  assign {bi_on, bi_off, pick, t1p, t3p, brdy, bopen, mclose} =
         PRESENT ? s2_ff : '0;
  assign trip        = t1p | t3p;
  assign trip_rise   = trip & ~(prev_ff[4] | prev_ff[3]);
  assign mclose_rise = mclose & ~prev_ff[0];

  // Registers.
  logic [31:0] ctrl_ff, nxt_ctrl;
  logic [31:0] tset_ff [NT], nxt_tset [NT];
  logic [31:0] cyc_ff [lar_pkg::NSET], nxt_cyc [lar_pkg::NSET];
  logic        bi_off_ff, nxt_bi_off, si_off_ff, nxt_si_off;
  logic        si_mem_ff, nxt_si_mem;

  // AXI4-Lite handshake state.
  logic       aw_ff, nxt_aw, w_ff, nxt_w, bv_ff, nxt_bv, ar_ff, nxt_ar;
  logic       rv_ff, nxt_rv;
  logic [7:0] awa_ff, nxt_awa;
  logic [31:0] wd_ff, nxt_wd, rd_ff, nxt_rd;
  logic [3:0] ws_ff, nxt_ws;
  logic [1:0] br_ff, nxt_br, rr_ff, nxt_rr;
  logic       wr_go;
  logic [2:0] w_idx;

  function automatic logic [31:0] merge(input logic [31:0] o,
                                        input logic [31:0] d,
                                        input logic [3:0] s);
    logic [31:0] r;
    r = o;
    for (int b = 0; b < 4; b++) begin
      if (s[b]) r[b*8 +: 8] = d[b*8 +: 8];
    end
    return r;
  endfunction : merge

  // Sequencer state.
  lar_pkg::lar_state_e st_ff, nxt_st;
  logic [3:0] cyc_cnt_ff, nxt_cyc_cnt;
  logic       evo_ff, nxt_evo, three_ff, nxt_three, block_ff, nxt_block;
  logic       close_ff, nxt_close, rem_ff, nxt_rem, ftrip_ff, nxt_ftrip;
  logic       act_ff, nxt_act;
  logic [TK_W-1:0] tk_ff, nxt_tk;
  logic       tick_ff, nxt_tick;
  logic       active;

  always_comb begin
    nxt_aw = aw_ff; nxt_w = w_ff; nxt_awa = awa_ff; nxt_wd = wd_ff;
    nxt_ws = ws_ff; nxt_bv = bv_ff; nxt_br = br_ff;
    nxt_ar = ar_ff; nxt_rv = rv_ff; nxt_rd = rd_ff; nxt_rr = rr_ff;
    if (AWVALID_I && !aw_ff && !bv_ff) begin
      nxt_aw = 1'b1; nxt_awa = AWADDR_I;
    end
    if (WVALID_I && !w_ff && !bv_ff) begin
      nxt_w = 1'b1; nxt_wd = WDATA_I; nxt_ws = WSTRB_I;
    end
    if (wr_go) begin
      nxt_aw = 1'b0; nxt_w = 1'b0; nxt_bv = 1'b1;
      nxt_br = (awa_ff[1:0] == 2'h0 && awa_ff < 8'h50 &&
                !(awa_ff > lar_pkg::A_DEAD3EV && awa_ff < lar_pkg::A_CYC0))
               ? 2'h0 : 2'h2;
    end
    if (bv_ff && BREADY_I) nxt_bv = 1'b0;
    if (ARVALID_I && !ar_ff && !rv_ff) begin
      nxt_ar = 1'b1;
      nxt_rv = 1'b1;
      nxt_rr = 2'h0;
      nxt_rd = 32'h0;
      unique case (ARADDR_I)
        lar_pkg::A_CTRL: nxt_rd = ctrl_ff;
        lar_pkg::A_STAT: nxt_rd = {20'h0, cyc_cnt_ff, 1'b0, st_ff,
                                   si_off_ff, bi_off_ff, block_ff, active};
        lar_pkg::A_BRKWAIT, lar_pkg::A_DEADEXT, lar_pkg::A_RECLAIM,
        lar_pkg::A_MCBLK, lar_pkg::A_OPENWT, lar_pkg::A_REMDLY,
        lar_pkg::A_DEAD3EV: nxt_rd = tset_ff[ARADDR_I[4:2] - 3'h2];
        8'h40, 8'h44, 8'h48, 8'h4c: nxt_rd = cyc_ff[ARADDR_I[3:2]];
        default: nxt_rr = 2'h2;
      endcase
    end else begin
      nxt_ar = 1'b0;
    end
    if (rv_ff && RREADY_I) nxt_rv = 1'b0;
  end
  assign wr_go = aw_ff && w_ff && !bv_ff;
  assign w_idx = awa_ff[4:2] - 3'h2;

  always_comb begin
    nxt_ctrl = ctrl_ff;
    nxt_tset = tset_ff;
    nxt_cyc  = cyc_ff;
    nxt_si_off = si_off_ff;
    nxt_si_mem = si_mem_ff;
    nxt_bi_off = bi_off_ff;
    if (wr_go) begin
      if (awa_ff == lar_pkg::A_CTRL) begin
        nxt_ctrl = merge(ctrl_ff, wd_ff, ws_ff);
        nxt_ctrl[lar_pkg::C_SI_OFF] = 1'b0;
        nxt_ctrl[lar_pkg::C_SI_ON]  = 1'b0;
        // Interface off/on commands touch only the interface source.
        if (ws_ff[0] && wd_ff[lar_pkg::C_SI_OFF]) begin
          nxt_si_off = 1'b1; nxt_si_mem = 1'b1;
        end else if (ws_ff[0] && wd_ff[lar_pkg::C_SI_ON]) begin
          nxt_si_off = 1'b0; nxt_si_mem = 1'b0;
        end
      end else if (awa_ff >= lar_pkg::A_BRKWAIT &&
                   awa_ff <= lar_pkg::A_DEAD3EV) begin
        nxt_tset[w_idx] = merge(tset_ff[w_idx], wd_ff, ws_ff);
      end else if (awa_ff >= lar_pkg::A_CYC0 && awa_ff[7:4] == 4'h4) begin
        nxt_cyc[awa_ff[3:2]] = merge(cyc_ff[awa_ff[3:2]], wd_ff, ws_ff);
      end
    end
    // The binary-input source is switched only by its own pins.
    if (bi_off)      nxt_bi_off = 1'b1;
    else if (bi_on)  nxt_bi_off = 1'b0;
  end

  assign active = PRESENT && ctrl_ff[lar_pkg::C_PARAM_ON] &&
                  !bi_off_ff && !si_off_ff;

  // Timers: 0 open watch, 1 dead, 2 breaker wait, 3 extension,
  // 4 reclaim, 5 manual block, 6 remote delay.
  lar_tmr_if ti [NT] ();
  logic [NT-1:0] t_start, t_exp, t_run;
  logic [lar_pkg::TW-1:0] t_load [NT];
  for (genvar g = 0; g < NT; g++) begin : g_tmr
    assign ti[g].tick  = tick_ff;
    assign ti[g].start = t_start[g];
    assign ti[g].stop  = !active;
    assign ti[g].load  = t_load[g];
    assign t_exp[g]    = ti[g].expired;
    assign t_run[g]    = ti[g].running;
    lar_timer u_tmr (.clk_i(CLOCK_I), .rst_b_i(RST_B_I), .t(ti[g]));
  end

  logic [1:0]  sel;
  logic [15:0] d1, d3;
  assign sel = (cyc_cnt_ff >= 4'h4) ? 2'h3 : 2'(cyc_cnt_ff);
  assign d1  = cyc_ff[sel][15:0];
  assign d3  = cyc_ff[sel][31:16];

  always_comb begin
    nxt_st = st_ff; nxt_cyc_cnt = cyc_cnt_ff; nxt_evo = evo_ff;
    nxt_three = three_ff; nxt_block = block_ff; nxt_close = 1'b0;
    nxt_rem = rem_ff; nxt_ftrip = ftrip_ff; nxt_act = active;
    nxt_tick = 1'b0;
    nxt_tk = tk_ff + TK_W'(1);
    if (tk_ff == TK_W'(lar_pkg::TICK_CYC - 1)) begin
      nxt_tk = '0; nxt_tick = 1'b1;
    end
    t_start = '0;
    t_load[0] = lar_pkg::TW'(tset_ff[4]);
    t_load[1] = t3p || three_ff ? d3 : d1;
    t_load[2] = lar_pkg::TW'(tset_ff[0]);
    t_load[3] = lar_pkg::TW'(tset_ff[1]);
    t_load[4] = lar_pkg::TW'(tset_ff[2]);
    t_load[5] = lar_pkg::TW'(tset_ff[3]);
    t_load[6] = lar_pkg::TW'(tset_ff[5]);
    if (evo_ff && ctrl_ff[lar_pkg::C_EV_3P]) begin
      t_load[1] = lar_pkg::TW'(tset_ff[6]);
    end
    if (mclose_rise) t_start[5] = 1'b1;
    if (t_exp[6] && rem_ff) nxt_rem = 1'b0;
    if (!active) begin
      nxt_st = lar_pkg::ST_IDLE; nxt_cyc_cnt = '0; nxt_evo = 1'b0;
      nxt_three = 1'b0; nxt_ftrip = 1'b0; nxt_rem = 1'b0;
    end else begin
      unique case (st_ff)
        lar_pkg::ST_IDLE, lar_pkg::ST_RECL: begin
          if (st_ff == lar_pkg::ST_RECL && t_exp[4]) begin
            nxt_st = lar_pkg::ST_IDLE; nxt_cyc_cnt = '0;
            nxt_block = 1'b0;
          end
          if (trip_rise) begin
            nxt_three = t3p;
            t_start[0] = 1'b1;
            if ((pick || trip) && t_run[5]) begin
              nxt_st = lar_pkg::ST_LOCK; nxt_ftrip = 1'b1;
            end else if (st_ff == lar_pkg::ST_IDLE &&
                         ctrl_ff[lar_pkg::C_CHK1] && !brdy) begin
              nxt_st = lar_pkg::ST_LOCK;
            end else if (cyc_cnt_ff >= lar_pkg::MAX_CYC ||
                         cyc_cnt_ff >= ctrl_ff[lar_pkg::C_NCYC_LSB +:
                                               lar_pkg::C_NCYC_W]) begin
              nxt_st = lar_pkg::ST_LOCK;
            end else if ((t3p ? d3 : d1) == 16'h0) begin
              nxt_st = lar_pkg::ST_LOCK;
            end else begin
              nxt_st = lar_pkg::ST_OPENW;
            end
          end
        end
        lar_pkg::ST_OPENW: begin
          if (t3p) nxt_three = 1'b1;
          if (bopen || !trip) begin
            nxt_st = lar_pkg::ST_DEAD;
            t_start[1] = 1'b1;
            t_start[2] = 1'b1;
          end else if (t_exp[0]) begin
            nxt_st = lar_pkg::ST_LOCK; nxt_block = 1'b1;
          end
        end
        lar_pkg::ST_DEAD, lar_pkg::ST_EXT: begin
          if ((ctrl_ff[lar_pkg::C_EV_TRIP] ? trip_rise : pick) && !evo_ff) begin
            nxt_evo = 1'b1;
            if (!ctrl_ff[lar_pkg::C_EV_3P]) begin
              nxt_st = lar_pkg::ST_LOCK;
            end else begin
              nxt_st = lar_pkg::ST_OPENW; nxt_three = 1'b1;
              t_start[0] = 1'b1;
            end
          end else if (t_exp[2] && !brdy) begin
            nxt_st = lar_pkg::ST_LOCK; nxt_block = 1'b1;
          end else if (st_ff == lar_pkg::ST_DEAD && t_exp[1]) begin
            if (!brdy && tset_ff[0][31]) begin
              nxt_st = lar_pkg::ST_EXT;
              if (t_load[3] != lar_pkg::T_INF) t_start[3] = 1'b1;
            end else nxt_st = lar_pkg::ST_CLOSE;
          end else if (st_ff == lar_pkg::ST_EXT) begin
            if (brdy) nxt_st = lar_pkg::ST_CLOSE;
            else if (t_exp[3]) begin
              nxt_st = lar_pkg::ST_LOCK; nxt_block = 1'b1;
            end
          end
        end
        lar_pkg::ST_CLOSE: begin
          nxt_close = 1'b1;
          nxt_cyc_cnt = cyc_cnt_ff + 4'h1;
          nxt_evo = 1'b0;
          nxt_st = lar_pkg::ST_RECL;
          t_start[4] = 1'b1;
          // Manual-close blocking is not restarted by an automatic close,
          // so a re-trip in the reclaim time still starts the next cycle.
          if (ctrl_ff[lar_pkg::C_REM_ADAPT]) begin
            nxt_rem = 1'b0; t_start[6] = 1'b1;
          end
        end
        lar_pkg::ST_LOCK: begin
          if (!trip && !pick) begin
            nxt_st = lar_pkg::ST_IDLE; nxt_cyc_cnt = '0; nxt_ftrip = 1'b0;
          end
        end
        default: nxt_st = lar_pkg::ST_LOCK;
      endcase
    end
    if (t_exp[6] && ctrl_ff[lar_pkg::C_REM_ADAPT]) nxt_rem = 1'b1;
    if (rem_ff && !t_exp[6]) nxt_rem = 1'b0;
  end

  always_ff @(posedge CLOCK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      aw_ff <= 1'b0; w_ff <= 1'b0; bv_ff <= 1'b0; ar_ff <= 1'b0;
      rv_ff <= 1'b0; awa_ff <= '0; wd_ff <= '0; ws_ff <= '0;
      rd_ff <= '0; br_ff <= '0; rr_ff <= '0;
      ctrl_ff <= lar_pkg::CTRL_RST;
      tset_ff <= '{default: lar_pkg::T_RST};
      cyc_ff  <= '{default: lar_pkg::CYC_RST};
      bi_off_ff <= 1'b0;
      si_off_ff <= 1'b0; si_mem_ff <= 1'b0;
      st_ff <= lar_pkg::ST_IDLE; cyc_cnt_ff <= '0; evo_ff <= 1'b0;
      three_ff <= 1'b0; block_ff <= 1'b0; close_ff <= 1'b0;
      rem_ff <= 1'b0; ftrip_ff <= 1'b0; act_ff <= 1'b0;
      tk_ff <= '0; tick_ff <= 1'b0;
    end else begin
      aw_ff <= nxt_aw; w_ff <= nxt_w; bv_ff <= nxt_bv; ar_ff <= nxt_ar;
      rv_ff <= nxt_rv; awa_ff <= nxt_awa; wd_ff <= nxt_wd; ws_ff <= nxt_ws;
      rd_ff <= nxt_rd; br_ff <= nxt_br; rr_ff <= nxt_rr;
      ctrl_ff <= nxt_ctrl; tset_ff <= nxt_tset; cyc_ff <= nxt_cyc;
      bi_off_ff <= nxt_bi_off;
      si_off_ff <= nxt_si_off; si_mem_ff <= nxt_si_mem;
      st_ff <= nxt_st; cyc_cnt_ff <= nxt_cyc_cnt; evo_ff <= nxt_evo;
      three_ff <= nxt_three; block_ff <= nxt_block;
      close_ff <= nxt_close && PRESENT;
      rem_ff <= nxt_rem && PRESENT;
      ftrip_ff <= nxt_ftrip && PRESENT;
      act_ff <= nxt_act;
      tk_ff <= nxt_tk; tick_ff <= nxt_tick;
    end
  end

  assign AWREADY_O = aw_ff;
  assign WREADY_O  = w_ff;
  assign BVALID_O  = bv_ff;
  assign BRESP_O   = br_ff;
  assign ARREADY_O = ar_ff;
  assign RVALID_O  = rv_ff;
  assign RDATA_O   = rd_ff;
  assign RRESP_O   = rr_ff;
  assign CLOSE_CMD_O     = close_ff;
  assign REMOTE_CLOSE_O  = rem_ff;
  assign FINAL_TRIP_3P_O = ftrip_ff;
  assign RECL_ACTIVE_O   = act_ff;
endmodule : lar_top
`default_nettype wire

// >>> bench/lar_top_assertions.sv
// Port-level checker for the reclose sequencer top.
`timescale 1ns/1ps
`default_nettype none
module lar_top_chk #(
  parameter bit PRESENT = 1'b1
) (
  // Clock and reset
  input wire logic CLOCK_I,
  input wire logic RST_B_I,
  // Bus and pin inputs
  input wire logic AWVALID_I,
  input wire logic WVALID_I,
  input wire logic ARVALID_I,
  input wire logic BI_OFF_I,
  // Outputs
  input wire logic BVALID_O,
  input wire logic RVALID_O,
  input wire logic CLOSE_CMD_O,
  input wire logic REMOTE_CLOSE_O,
  input wire logic FINAL_TRIP_3P_O,
  input wire logic RECL_ACTIVE_O
);
  default clocking cb @(posedge CLOCK_I); endclocking
  default disable iff (!RST_B_I);
  a_absent_silent: assert property (
    !PRESENT |-> !RECL_ACTIVE_O && !CLOSE_CMD_O) else $error("absent drives");
  a_inactive_no_close: assert property (
    !RECL_ACTIVE_O && !$past(RECL_ACTIVE_O) |-> !CLOSE_CMD_O)
    else $error("close while off");
  a_startup_active: assert property (
    $rose(RST_B_I) && PRESENT && !BI_OFF_I |-> ##[1:6] RECL_ACTIVE_O)
    else $error("not active at start");
  a_bi_off_holds: assert property (
    BI_OFF_I [*5] |-> !RECL_ACTIVE_O) else $error("active with input off");
  a_close_pulse: assert property (
    CLOSE_CMD_O |=> !CLOSE_CMD_O) else $error("close too long");
  a_remote_pulse: assert property (
    REMOTE_CLOSE_O |=> !REMOTE_CLOSE_O) else $error("remote too long");
  a_final_no_close: assert property (
    FINAL_TRIP_3P_O |-> !CLOSE_CMD_O) else $error("close on final trip");
  a_write_answer: assert property (
    AWVALID_I && WVALID_I && !BVALID_O |-> ##[1:3] BVALID_O)
    else $error("no write response");
  a_read_answer: assert property (
    ARVALID_I && !RVALID_O |-> ##[1:2] RVALID_O) else $error("no read data");
endmodule : lar_top_chk
bind lar_top lar_top_chk #(.PRESENT(PRESENT)) u_chk (.CLOCK_I, .RST_B_I,
  .AWVALID_I, .WVALID_I, .ARVALID_I, .BI_OFF_I, .BVALID_O, .RVALID_O,
  .CLOSE_CMD_O, .REMOTE_CLOSE_O, .FINAL_TRIP_3P_O, .RECL_ACTIVE_O);
`default_nettype wire

// >>> bench/lar_breaker_model.sv
// Behavioural breaker: opens on a trip, closes on a close command.
`timescale 1ns/1ps
`default_nettype none
module lar_breaker_model #(
  parameter int unsigned OP_CYC = 4
) (
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic rst_b_i,
  // Commands
  input  wire logic trip_i,
  input  wire logic close_i,
  // Breaker state
  output logic      open_o,
  output logic      ready_o
);
  int unsigned cnt;
  logic        tgt;
  // A close clears the open target even under a live trip, but the trip sets it again, so it stays open.
  always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      {tgt, open_o, ready_o} <= 3'b001;
      cnt <= 0;
    end else if (trip_i && !tgt) begin
      tgt <= 1'b1;
      cnt <= OP_CYC;
    end else if (close_i && tgt) begin
      tgt <= 1'b0;
      cnt <= OP_CYC;
    end else if (cnt > 1) begin
      cnt <= cnt - 1;
    end else begin
      open_o <= tgt;
    end
  end
endmodule : lar_breaker_model
`default_nettype wire

// >>> bench/test_lar_top.sv
// Self-checking bench for the reclose sequencer top.
`timescale 1ns/1ps
`default_nettype none
module test_lar_top;
  logic        clk = 1'b0;
  logic        rst_b, awv, awr, wv, wr_, bv, bready, arv, arr, rv, rready;
  logic        bi_on, bi_off, pick, t1p, t3p, rdy, opn, mcl;
  logic        close, rclose, ftrip, act;
  logic        rem_seen = 1'b0;
  logic [7:0]  awa, ara;
  logic [31:0] wd, rdat, got;
  logic [3:0]  ws;
  logic [1:0]  br, rr, resp;
  int          n_errors, check_count;
  lar_top dut (.CLOCK_I(clk), .RST_B_I(rst_b), .AWADDR_I(awa),
    .AWVALID_I(awv), .AWREADY_O(awr), .WDATA_I(wd), .WSTRB_I(ws),
    .WVALID_I(wv), .WREADY_O(wr_), .BRESP_O(br), .BVALID_O(bv),
    .BREADY_I(bready), .ARADDR_I(ara), .ARVALID_I(arv), .ARREADY_O(arr),
    .RDATA_O(rdat), .RRESP_O(rr), .RVALID_O(rv), .RREADY_I(rready),
    .BI_ON_I(bi_on), .BI_OFF_I(bi_off), .PICKUP_I(pick), .TRIP_1P_I(t1p),
    .TRIP_3P_I(t3p), .BRK_READY_I(rdy), .BRK_OPEN_I(opn),
    .MAN_CLOSE_I(mcl), .CLOSE_CMD_O(close), .REMOTE_CLOSE_O(rclose),
    .FINAL_TRIP_3P_O(ftrip), .RECL_ACTIVE_O(act));
  lar_breaker_model u_brk (.clk_i(clk), .rst_b_i(rst_b),
    .trip_i(t1p | t3p), .close_i(close), .open_o(opn), .ready_o(rdy));
  always #12.5 clk = ~clk;
  always @(posedge clk) if (rclose) rem_seen <= 1'b1;
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e) begin
      n_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    {awa, wd, awv, wv} <= {a, d, 2'b11};
    do begin
      @(posedge clk);
      if (awr) awv <= 1'b0;
      if (wr_) wv <= 1'b0;
    end while (!bv);
    resp = br;
    @(posedge clk);
  endtask : wr
  task automatic rd(input logic [7:0] a);
    {ara, arv} <= {a, 1'b1};
    do begin
      @(posedge clk);
      if (arr) arv <= 1'b0;
    end while (!rv);
    {got, resp} = {rdat, rr};
    @(posedge clk);
  endtask : rd
  // Enable changes go through input synchronisers, so allow them to land.
  task automatic act_is(input logic e);
    repeat (8) @(posedge clk);
    chk({31'h0, act}, {31'h0, e});
  endtask : act_is
  task automatic t_regs();
    rd(lar_pkg::A_CTRL);
    chk(got, lar_pkg::CTRL_RST);
    for (int i = 0; i < 4; i++) begin
      rd(8'(lar_pkg::A_CYC0 + 4 * i));
      chk(got, lar_pkg::CYC_RST);
    end
    rd(lar_pkg::A_RECLAIM);
    chk(got, lar_pkg::T_RST);
    rd(8'h80);
    chk({30'h0, resp}, 32'h2);
  endtask : t_regs
  task automatic t_enables();
    act_is(1'b1);
    wr(lar_pkg::A_CTRL, 32'h0000_0103);
    act_is(1'b0);
    bi_off <= 1'b1;
    wr(lar_pkg::A_CTRL, 32'h0000_0105);
    act_is(1'b0);
    bi_off <= 1'b0;
    act_is(1'b0);
    bi_on <= 1'b1;
    act_is(1'b1);
    bi_on <= 1'b0;
    wr(lar_pkg::A_CTRL, 32'h0000_0100);
    act_is(1'b0);
    wr(lar_pkg::A_CTRL, 32'h0000_0101);
    act_is(1'b1);
  endtask : t_enables
  task automatic pulse_trip();
    t1p <= 1'b1;
    repeat (8) @(posedge clk);
    t1p <= 1'b0;
  endtask : pulse_trip
  // A one-tick dead time ends at the next tick, up to one tick period away.
  task automatic wait_close();
    int n;
    n = 0;
    while (!close && n < 50000) begin
      @(posedge clk);
      n++;
    end
    chk({31'h0, close}, 32'h1);
  endtask : wait_close
  task automatic t_reclose();
    wr(lar_pkg::A_BRKWAIT, 32'h0000_0001);
    wr(lar_pkg::A_OPENWT, 32'h0000_0002);
    wr(lar_pkg::A_RECLAIM, 32'h0000_0001);
    wr(lar_pkg::A_CYC0, 32'h0000_0001);
    pulse_trip();
    wait_close();
    chk({31'h0, ftrip}, 32'h0);
    rd(lar_pkg::A_STAT);
    chk({28'h0, got[11:8]}, 32'h1);
    chk({31'h0, rem_seen}, 32'h0);
  endtask : t_reclose
  // Second cycle inside the reclaim time with an adaptive far end, then a
  // third trip once the allowed cycles are used up.
  task automatic t_retrip();
    wr(lar_pkg::A_CTRL, 32'h0000_0241);
    wr(8'(lar_pkg::A_CYC0 + 4), 32'h0000_0001);
    wr(lar_pkg::A_REMDLY, 32'h0000_0000);
    repeat (8) @(posedge clk);
    pulse_trip();
    wait_close();
    rd(lar_pkg::A_STAT);
    chk({28'h0, got[11:8]}, 32'h2);
    chk({31'h0, rem_seen}, 32'h1);
    t1p <= 1'b1;
    repeat (4) @(posedge clk);
    rd(lar_pkg::A_STAT);
    chk({29'h0, got[6:4]}, 32'(lar_pkg::ST_LOCK));
    t1p <= 1'b0;
  endtask : t_retrip
  task automatic conclude();
    $display("errors=%0d checks=%0d", n_errors, check_count);
    if (n_errors == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : conclude
  initial begin
    #2_400_000;
    n_errors++;
    conclude();
  end
  initial begin
    {awv, wv, arv, pick, t1p, t3p, mcl, bi_on, bi_off} = '0;
    {bready, rready, ws, awa, ara, wd} = {2'b11, 4'hf, 48'h0};
    {rst_b, n_errors, check_count} = '0;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    t_regs();
    t_enables();
    t_reclose();
    t_retrip();
    conclude();
  end
endmodule : test_lar_top
`default_nettype wire
